// File: hdl/count_clock_if.sv
`timescale 1ns/100ps
interface count_clock_if;
    logic [2:0] clk_sel;
    logic       tick;

    modport src  (input  clk_sel, output tick);
    modport user (output clk_sel, input  tick);
endinterface

// File: hdl/count_clock_source.sv
`timescale 1ns/100ps
`include "reload_timer_defs.svh"
module count_clock_source #(
    parameter int PRESC_STAGES = 7
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ext_clk_pin,
    count_clock_if.src       cc
);

    logic [PRESC_STAGES-1:0] presc_reg;
    logic [PRESC_STAGES-1:0] int_tick;
    logic                    ext_meta_reg;
    logic                    ext_sync_reg;
    logic                    ext_prev_reg;
    logic                    ext_edge;
    logic                    tick_next;

    generate
        if (PRESC_STAGES < 1 || PRESC_STAGES > 7) begin : g_bad
            $error("PRESC_STAGES must be 1 to 7");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    // Stage k pulses once every 2^(k+1) system clocks
    genvar k;
    generate
        for (k = 0; k < PRESC_STAGES; k++) begin : g_tap
            assign int_tick[k] = &presc_reg[k:0];
        end
    endgenerate

    // Pin is asynchronous to clk; edges are taken from the second and third stages
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clk_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_edge = ext_sync_reg & ~ext_prev_reg;

    always_comb begin
        tick_next = 1'b0;
        if (cc.clk_sel == `SEL_EXT) begin
            tick_next = ext_edge;
        end else if (int'(cc.clk_sel) < PRESC_STAGES) begin
            tick_next = int_tick[cc.clk_sel];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cc.tick <= 1'b0;
        end else begin
            cc.tick <= tick_next;
        end
    end

    AST_EXT_EDGE_TICK: assert property (@(posedge clk) disable iff (rst)
        (cc.clk_sel == `SEL_EXT && $stable(cc.clk_sel) && ext_edge) |=> cc.tick)
        else $error("external edge did not give a count tick");

    COV_EXT_TICK: cover property (@(posedge clk) disable iff (rst)
        cc.clk_sel == `SEL_EXT && cc.tick);

endmodule

// File: hdl/reload_timer.sv
`timescale 1ns/100ps
`include "reload_timer_defs.svh"
// How it works
// - Write-only eight-bit reload value register.
// - Writing reload also loads the counter.
// - Auto-reload mode: overflow loads reload value.
// - Overflow period 1 to 256 count clocks.
// - Reload write and count read share address.
// - Reload register resets to zero.
// - Mode bit selects interval or auto-reload.
// - Reset clears counter and mode, counting starts.
// - Three-bit select: seven prescalers or pin.
// - Count clock at maximum sets overflow flag.
// - Flag and enable together request interrupt.
// - Interval mode: overflow wraps counter to zero.
// - Both modes share clocks, flag and interrupt.
module reload_timer
    import reload_timer_pkg::*;
#(
    parameter int ADDR_W       = 5,
    parameter int PRESC_STAGES = 7
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ext_clk_pin,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq
);

    generate
        if (ADDR_W < 5) begin : g_bad_addr
            $error("ADDR_W must be at least 5");
        end
    endgenerate

    count_clock_if cc ();

    wr_state_t         wr_state_reg;
    rd_state_t         rd_state_reg;
    logic              aw_have_reg;
    logic              w_have_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              aw_fire;
    logic              w_fire;
    logic              ar_fire;
    logic              wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic              wr_lane0;
    logic              wr_mapped;
    logic              rd_mapped;
    logic [31:0]       rd_mux;

    logic [7:0]        timer_reload_value_reg;
    logic [7:0]        timer_count_value_reg;
    logic              auto_reload_select_reg;
    logic [2:0]        clock_select_reg;
    logic              overflow_flag_reg;
    logic              overflow_irq_enable_reg;

    logic              wr_count;
    logic              wr_mode;
    logic              wr_flag;
    logic              wr_enable;
    logic              ovf_evt;

    count_clock_source #(
        .PRESC_STAGES (PRESC_STAGES)
    ) u_src (
        .clk         (clk),
        .rst         (rst),
        .ext_clk_pin (ext_clk_pin),
        .cc          (cc.src)
    );

    assign cc.clk_sel = clock_select_reg;

    // Bus handshakes and decode

    assign aw_fire  = s_axi_awvalid & s_axi_awready;
    assign w_fire   = s_axi_wvalid & s_axi_wready;
    assign ar_fire  = s_axi_arvalid & s_axi_arready;
    assign wr_go    = (wr_state_reg == WR_IDLE)
                    & (aw_have_reg | aw_fire) & (w_have_reg | w_fire);
    assign wr_addr  = aw_have_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_byte  = w_have_reg ? wdata_reg[7:0] : s_axi_wdata[7:0];
    assign wr_lane0 = w_have_reg ? wstrb_reg[0] : s_axi_wstrb[0];

    assign wr_mapped = (wr_addr[ADDR_W-1:4] == '0);
    assign rd_mapped = (s_axi_araddr[ADDR_W-1:4] == '0);

    // All fields live in byte lane 0; other lanes are ignored
    assign wr_count  = wr_go & wr_lane0 & wr_mapped & (wr_addr[3:0] == `OFF_COUNT);
    assign wr_mode   = wr_go & wr_lane0 & wr_mapped & (wr_addr[3:0] == `OFF_MODE);
    assign wr_flag   = wr_go & wr_lane0 & wr_mapped & (wr_addr[3:0] == `OFF_FLAG);
    assign wr_enable = wr_go & wr_lane0 & wr_mapped & (wr_addr[3:0] == `OFF_ENABLE);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_state_reg  <= WR_IDLE;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
        end else begin
            case (wr_state_reg)
                WR_IDLE: begin
                    if (aw_fire) begin
                        awaddr_reg    <= s_axi_awaddr;
                        aw_have_reg   <= 1'b1;
                        s_axi_awready <= 1'b0;
                    end
                    if (w_fire) begin
                        wdata_reg    <= s_axi_wdata;
                        wstrb_reg    <= s_axi_wstrb;
                        w_have_reg   <= 1'b1;
                        s_axi_wready <= 1'b0;
                    end
                    if (wr_go) begin
                        s_axi_awready <= 1'b0;
                        s_axi_wready  <= 1'b0;
                        s_axi_bvalid  <= 1'b1;
                        s_axi_bresp   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                        wr_state_reg  <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        aw_have_reg   <= 1'b0;
                        w_have_reg    <= 1'b0;
                        wr_state_reg  <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_reg <= WR_IDLE;
                end
            endcase
        end
    end

    // Reload value is write-only: its offset reads back the live counter
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr[3:0])
            `OFF_COUNT:  rd_mux[7:0] = timer_count_value_reg;
            `OFF_MODE: begin
                rd_mux[`MODE_AUTO_BIT]               = auto_reload_select_reg;
                rd_mux[`MODE_SEL_MSB:`MODE_SEL_LSB]  = clock_select_reg;
            end
            `OFF_FLAG:   rd_mux[`FLAG_OVF_BIT] = overflow_flag_reg;
            `OFF_ENABLE: rd_mux[`FLAG_OVF_BIT] = overflow_irq_enable_reg;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_state_reg  <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rd_state_reg)
                RD_IDLE: begin
                    if (ar_fire) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= rd_mapped ? rd_mux : 32'h0000_0000;
                        s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                        rd_state_reg  <= RD_DATA;
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state_reg  <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end

    // Timer core

    assign ovf_evt = cc.tick & (timer_count_value_reg == `COUNT_MAX) & ~wr_count;

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_reload_value_reg <= `RELOAD_RST;
        end else if (wr_count) begin
            timer_reload_value_reg <= wr_byte;
        end
    end

    // A software write beats a simultaneous count tick; that tick is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_count_value_reg <= `COUNT_RST;
        end else if (wr_count) begin
            timer_count_value_reg <= wr_byte;
        end else if (ovf_evt) begin
            if (auto_reload_select_reg) begin
                timer_count_value_reg <= timer_reload_value_reg;
            end else begin
                timer_count_value_reg <= `COUNT_RST;
            end
        end else if (cc.tick) begin
            timer_count_value_reg <= timer_count_value_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            auto_reload_select_reg <= 1'b0;
            clock_select_reg       <= `SEL_RST;
        end else if (wr_mode) begin
            auto_reload_select_reg <= wr_byte[`MODE_AUTO_BIT];
            clock_select_reg       <= wr_byte[`MODE_SEL_MSB:`MODE_SEL_LSB];
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag_reg <= 1'b0;
        end else begin
            overflow_flag_reg <= (overflow_flag_reg
                                  & ~(wr_flag & wr_byte[`FLAG_OVF_BIT]))
                                 | ovf_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_irq_enable_reg <= 1'b0;
        end else if (wr_enable) begin
            overflow_irq_enable_reg <= wr_byte[`FLAG_OVF_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= overflow_flag_reg & overflow_irq_enable_reg;
        end
    end

    // Checks

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_RESET_STATE: assert property (
        $fell(rst) |-> timer_count_value_reg == 8'h00
        && timer_reload_value_reg == 8'h00 && !auto_reload_select_reg)
        else $error("timer state not cleared by reset");

    AST_RELOAD_WRITE: assert property (
        wr_count |=> timer_count_value_reg == $past(wr_byte)
        && timer_reload_value_reg == $past(wr_byte))
        else $error("reload write did not load counter and reload value");

    AST_AUTO_RELOAD: assert property (
        ovf_evt && auto_reload_select_reg |=>
        timer_count_value_reg == $past(timer_reload_value_reg))
        else $error("auto-reload overflow did not load reload value");

    AST_INTERVAL_WRAP: assert property (
        ovf_evt && !auto_reload_select_reg |=> timer_count_value_reg == 8'h00)
        else $error("interval overflow did not wrap to zero");

    AST_COUNT_STEP: assert property (
        cc.tick && !wr_count && timer_count_value_reg != 8'hff |=>
        timer_count_value_reg == $past(timer_count_value_reg) + 8'h01)
        else $error("counter did not advance by one on a tick");

    // Between count clocks the counter must hold, or the period would drift
    AST_TICK_HOLD: assert property (
        !cc.tick && !wr_count |=> $stable(timer_count_value_reg))
        else $error("counter moved without a count tick");

    AST_FLAG_SET: assert property (
        cc.tick && !wr_count && timer_count_value_reg == 8'hff |=> overflow_flag_reg)
        else $error("overflow did not set the flag");

    AST_FLAG_CLEAR: assert property (
        wr_flag && wr_byte[`FLAG_OVF_BIT] && !ovf_evt |=> !overflow_flag_reg)
        else $error("write of one did not clear the flag");

    AST_MODE_WRITE: assert property (
        wr_mode |=> auto_reload_select_reg == $past(wr_byte[`MODE_AUTO_BIT])
        && clock_select_reg == $past(wr_byte[`MODE_SEL_MSB:`MODE_SEL_LSB]))
        else $error("mode write did not update mode and clock select");

    AST_IRQ_LEVEL: assert property (
        overflow_flag_reg && overflow_irq_enable_reg |=> irq)
        else $error("interrupt not raised for enabled flag");

    AST_IRQ_QUIET: assert property (
        !overflow_irq_enable_reg || !overflow_flag_reg |=> !irq)
        else $error("interrupt raised without an enabled flag");

    AST_READ_COUNT: assert property (
        ar_fire && rd_mapped && s_axi_araddr[3:0] == `OFF_COUNT |=>
        s_axi_rvalid && s_axi_rdata == {24'h000000, $past(timer_count_value_reg)})
        else $error("count offset did not read the counter");

    COV_AUTO_OVF: cover property (ovf_evt && auto_reload_select_reg);
    COV_INTERVAL_OVF: cover property (ovf_evt && !auto_reload_select_reg);
    COV_IRQ_RISE: cover property ($rose(irq));
    COV_SET_CLEAR_CLASH: cover property (ovf_evt && wr_flag);

endmodule

// File: hdl/reload_timer_defs.svh
`ifndef RELOAD_TIMER_DEFS_SVH
`define RELOAD_TIMER_DEFS_SVH

// Register offsets within the low address nibble
`define OFF_COUNT      4'h0
`define OFF_MODE       4'h4
`define OFF_FLAG       4'h8
`define OFF_ENABLE     4'hc

// Field positions
`define MODE_AUTO_BIT  7
`define MODE_SEL_MSB   2
`define MODE_SEL_LSB   0
`define FLAG_OVF_BIT   0

// Reset values and counter limits
`define RELOAD_RST     8'h00
`define COUNT_RST      8'h00
`define COUNT_MAX      8'hff
`define SEL_RST        3'h0
`define SEL_EXT        3'h7

`endif

// File: hdl/reload_timer_pkg.sv
package reload_timer_pkg;

    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

endpackage

// File: tb/eight_bit_reload_timer_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module eight_bit_reload_timer_tb_top;
    logic        clk;
    logic        rst;
    logic        ext_clk_pin;
    logic [4:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [4:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        irq;
    int          failures;
    int          tests_run;

    reload_timer uut (
        .clk(clk), .rst(rst), .ext_clk_pin(ext_clk_pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic too_long;
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    // Master side: both address and data offered together, bready held until the answer
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (s_axi_bvalid !== 1'b1) too_long();
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (s_axi_rvalid !== 1'b1) too_long();
    endtask

    task automatic wreg(input logic [4:0] a, input logic [7:0] v);
        logic [1:0] r;
        wr(a, {24'h0, v}, r);
    endtask

    task automatic rv(input logic [4:0] a, output logic [7:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        v = d[7:0];
    endtask

    // Polls the flag register; a flag that never rises ends the run
    task automatic wait_flag;
        logic [7:0] v;
        int         i;
        for (i = 0; i < 400; i++) begin
            rv(5'h08, v);
            if (v[0] === 1'b1) break;
        end
        if (i >= 400) too_long();
    endtask

    task automatic t_reset;
        logic [7:0] a;
        logic [7:0] b;
        rv(5'h04, a);
        `CHK(a, 8'h00)
        rv(5'h08, a);
        `CHK(a, 8'h00)
        `CHK(irq, 1'b0)
        rv(5'h00, a);
        repeat (20) @(posedge clk);
        rv(5'h00, b);
        `CHK((8'(b - a) inside {[8'h0a:8'h0d]}), 1'b1)
        // Auto mode with the reload left at its reset value restarts from zero
        wreg(5'h04, 8'h80);
        wait_flag();
        rv(5'h00, a);
        `CHK((a < 8'h10), 1'b1)
    endtask

    task automatic t_modes;
        logic [7:0] v;
        wreg(5'h04, 8'h00);
        wreg(5'h08, 8'h01);
        wreg(5'h00, 8'hf0);
        rv(5'h08, v);
        `CHK(v, 8'h00)
        wait_flag();
        rv(5'h00, v);
        `CHK((v < 8'h10), 1'b1)
        wreg(5'h04, 8'h80);
        rv(5'h04, v);
        `CHK(v, 8'h80)
        wreg(5'h08, 8'h01);
        wreg(5'h00, 8'hc0);
        wait_flag();
        rv(5'h00, v);
        `CHK((v inside {[8'hc0:8'hcf]}), 1'b1)
        // Reload of the maximum gives a period of one count clock
        wreg(5'h00, 8'hff);
        repeat (10) @(posedge clk);
        rv(5'h00, v);
        `CHK(v, 8'hff)
        for (int m = 0; m < 2; m++) begin
            wreg(5'h04, m[0] ? 8'h80 : 8'h00);
            wreg(5'h00, 8'h40);
            rv(5'h00, v);
            `CHK((v inside {[8'h40:8'h43]}), 1'b1)
        end
    endtask

    task automatic t_irq;
        int n;
        logic [7:0] v;
        wreg(5'h0c, 8'h01);
        rv(5'h0c, v);
        `CHK(v, 8'h01)
        wreg(5'h08, 8'h01);
        wreg(5'h04, 8'h80);
        wreg(5'h00, 8'hf8);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        `CHK(irq, 1'b1)
        // Restart from zero so no overflow lands while the clear is checked
        wreg(5'h00, 8'h00);
        wreg(5'h08, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        wreg(5'h0c, 8'h00);
        wreg(5'h04, 8'h00);
        wreg(5'h00, 8'hfe);
        repeat (12) @(posedge clk);
        `CHK(irq, 1'b0)
        rv(5'h08, v);
        `CHK(v, 8'h01)
    endtask

    task automatic t_sel;
        logic [7:0] v;
        logic [7:0] e;
        for (int s = 1; s < 7; s++) begin
            wreg(5'h04, 8'(s));
            wreg(5'h00, 8'h00);
            repeat (256) @(posedge clk);
            rv(5'h00, v);
            e = 8'(256 >> (s + 1));
            `CHK((v inside {[e:e + 8'h02]}), 1'b1)
        end
        wreg(5'h04, 8'h87);
        rv(5'h04, v);
        `CHK(v, 8'h87)
        wreg(5'h00, 8'h00);
        repeat (20) @(posedge clk);
        rv(5'h00, v);
        `CHK(v, 8'h00)
        repeat (5) begin
            @(posedge clk);
            ext_clk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        rv(5'h00, v);
        `CHK(v, 8'h05)
    endtask

    // Reset in mid-run must put mode and counter back to their start values
    task automatic t_mid_reset;
        logic [7:0] v;
        wreg(5'h04, 8'h83);
        wreg(5'h00, 8'h90);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rv(5'h04, v);
        `CHK(v, 8'h00)
        rv(5'h00, v);
        `CHK((v < 8'h04), 1'b1)
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        wr(5'h14, 32'h0000_00ff, r);
        `CHK(r, 2'h2)
        rd(5'h18, d, r);
        `CHK(r, 2'h2)
        `CHK(d, 32'h0)
    endtask

    initial begin
        failures      = 0;
        tests_run     = 0;
        rst           = 1'b1;
        ext_clk_pin   = 1'b0;
        s_axi_awaddr  = 5'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 5'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_irq();
        t_sel();
        t_mid_reset();
        t_unmapped();
        conclude();
    end
endmodule
